// *** rtl/conv_regs_pkg.sv ***
// package for the converter clock, range and power register bank
// assumes a 32-bit Avalon-MM slave with byte addresses = 4 * register index
package conv_regs_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_CLOCK_NOISE    = 8'h2B;
    localparam logic [7:0] IDX_REF_EDGE_POS   = 8'h2C;
    localparam logic [7:0] IDX_FULLSCALE      = 8'h30;
    localparam logic [7:0] IDX_POWER_MODE     = 8'h37;
    localparam logic [7:0] IDX_TIMESTAMP_CTRL = 8'h3B;
    localparam logic [7:0] IDX_STATUS         = 8'h40;
    localparam int         ADDR_W             = 10;
    // reset values
    localparam logic [7:0]  RST_CLOCK_NOISE    = 8'h10;
    localparam logic [23:0] RST_REF_EDGE_POS   = 24'h000000;
    localparam logic [15:0] RST_FULLSCALE      = 16'hA000;
    localparam logic [7:0]  RST_POWER_MODE     = 8'h4B;
    localparam logic [7:0]  RST_TIMESTAMP_CTRL = 8'h00;
    // field positions
    localparam int BIT_ANALOG_QUIET = 2;
    localparam int BIT_CORE_QUIET   = 0;
    // operating mode codes
    localparam logic [7:0] MODE_HIGH_PERF = 8'h4B;
    localparam logic [7:0] MODE_LOW_POWER = 8'h46;
    localparam logic [15:0] FS_MIN_RECOMMENDED = 16'h2000;
    // status bit positions
    localparam int ST_LOW_POWER   = 0;
    localparam int ST_MODE_REJECT = 1;
    localparam int ST_FS_LOW      = 2;

    // bus request bundle
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } avm_req_t;

    // analog controls driven out of the bank
    typedef struct packed {
        logic        analog_clock_supply_quiet_en;
        logic        clock_core_supply_quiet_en;
        logic [15:0] fullscale_range;
        logic        low_power_mode;
        logic [7:0]  timestamp_input_control;
    } analog_ctrl_t;
endpackage : conv_regs_pkg

// *** rtl/edge_pos_capture.sv ***
// edge position capture: synchronises the 24-bit position word from the clock path
// assumes the source holds its word stable while its strobe toggles
module edge_pos_capture
    import conv_regs_pkg::*;
#(
    parameter int WIDTH = 24
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // asynchronous source
    input  wire logic             pos_toggle,
    input  wire logic [WIDTH-1:0] pos_word,
    // captured value
    output logic      [WIDTH-1:0] pos_value
);
    logic [2:0]       tog_reg, tog_next;
    logic [WIDTH-1:0] word1_reg, word1_next;
    logic [WIDTH-1:0] word2_reg, word2_next;
    logic [WIDTH-1:0] val_reg, val_next;

    // toggle crosses on two flops; third flop only feeds edge detect
    // the word also passes two flops so no logic reads the raw pins
    always_comb begin
        tog_next   = {tog_reg[1:0], pos_toggle};
        word1_next = pos_word;
        word2_next = word1_reg;
        val_next   = val_reg;
        if (tog_reg[2] != tog_reg[1]) begin
            val_next = word2_reg; // word has settled two flops behind the pins
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_reg   <= 3'h0;
            word1_reg <= '0;
            word2_reg <= '0;
            val_reg   <= WIDTH'(RST_REF_EDGE_POS);
        end else if (ce) begin
            tog_reg   <= tog_next;
            word1_reg <= word1_next;
            word2_reg <= word2_next;
            val_reg   <= val_next;
        end
    end

    assign pos_value = val_reg;
endmodule // edge_pos_capture

// *** rtl/conv_regs.sv ***
// converter clock noise, full-scale range and power mode register bank
// assumes an Avalon-MM master on REF_CLK and a position source in another domain
// Notes on behaviour
// R1: software keeps reserved clock-noise bits at default
// R2: clock noise register resets to 0x10
// R3: bit 2 enables analog clock supply quieting
// R4: bit 0 enables clock core supply quieting
// R5: read-only 24-bit edge position, resets zero
// R6: software uses position to pick delay
// R7: 16-bit full-scale range, resets 0xA000
// R8: software keeps full-scale at least 0x2000
// R9: mode 0x4B high performance, 0x46 low
// R10: software writes all power registers together
// R11: software recalibrates after mode change
// R12: software clears calibration and link first
module conv_regs
    import conv_regs_pkg::*;
(
    // clock, reset, enable
    input  wire logic                       REF_CLK,
    input  wire logic                       RST_N,
    input  wire logic                       CLK_EN,
    // avalon-mm slave
    input  wire conv_regs_pkg::avm_req_t    AVM_REQ,
    output logic                            AVM_WAITREQUEST,
    output logic      [31:0]                AVM_READDATA,
    output logic      [1:0]                 AVM_RESPONSE,
    // edge position source, other domain
    input  wire logic                       POS_TOGGLE,
    input  wire logic [23:0]                POS_WORD,
    // analog controls
    output conv_regs_pkg::analog_ctrl_t     ANALOG_CTRL
);
    import conv_regs_pkg::*;

    // register index decode, used for read and write
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:2];
    endfunction

    function automatic logic known_index(input logic [7:0] i);
        return (i == IDX_CLOCK_NOISE) || (i == IDX_REF_EDGE_POS) || (i == IDX_FULLSCALE) ||
               (i == IDX_POWER_MODE) || (i == IDX_TIMESTAMP_CTRL) || (i == IDX_STATUS);
    endfunction

    logic [7:0]  clk_noise_reg, clk_noise_next;
    logic [15:0] fs_reg, fs_next;
    logic [7:0]  mode_reg, mode_next;
    logic [7:0]  timestamp_input_reg, timestamp_input_next;
    logic        reject_reg, reject_next;
    logic        ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  resp_reg, resp_next;
    logic [23:0] edge_pos;
    logic [7:0]  idx;
    logic        req;

    // position word crosses from the clock path domain
    edge_pos_capture #(
        .WIDTH      (24)
    ) edge_pos_capture_i (
        .clk        (REF_CLK),
        .rst_n      (RST_N),
        .ce         (CLK_EN),
        .pos_toggle (POS_TOGGLE),
        .pos_word   (POS_WORD),
        .pos_value  (edge_pos)      // R5
    );

    assign idx = reg_index(AVM_REQ.address);
    assign req = (AVM_REQ.read || AVM_REQ.write) && !ack_reg;

    // one wait cycle: request taken when seen, answered with waitrequest low next cycle
    always_comb begin
        clk_noise_next = clk_noise_reg;
        fs_next        = fs_reg;
        mode_next      = mode_reg;
        timestamp_input_next     = timestamp_input_reg;
        reject_next    = reject_reg;
        ack_next       = 1'b0;
        rdata_next     = rdata_reg;
        resp_next      = resp_reg;
        if (req) begin
            ack_next  = 1'b1;
            resp_next = known_index(idx) ? 2'h0 : 2'h2; // slave error on unmapped
            if (AVM_REQ.write) begin
                case (idx)
                    IDX_CLOCK_NOISE: begin
                        // reserved bits are stored as written; software keeps defaults
                        if (AVM_REQ.byteenable[0]) clk_noise_next = AVM_REQ.writedata[7:0]; // R3 R4
                    end
                    IDX_FULLSCALE: begin
                        if (AVM_REQ.byteenable[0]) fs_next[7:0]  = AVM_REQ.writedata[7:0];   // R7
                        if (AVM_REQ.byteenable[1]) fs_next[15:8] = AVM_REQ.writedata[15:8];  // R7
                    end
                    IDX_POWER_MODE: begin
                        // reserved codes are refused so the mode stays defined
                        if (AVM_REQ.byteenable[0]) begin
                            if (AVM_REQ.writedata[7:0] == MODE_HIGH_PERF ||
                                AVM_REQ.writedata[7:0] == MODE_LOW_POWER) begin
                                mode_next = AVM_REQ.writedata[7:0]; // R9
                            end else begin
                                reject_next = 1'b1; // R9
                            end
                        end
                    end
                    IDX_TIMESTAMP_CTRL: begin
                        if (AVM_REQ.byteenable[0]) timestamp_input_next = AVM_REQ.writedata[7:0];
                    end
                    IDX_STATUS: begin
                        // write one clears the reject flag
                        if (AVM_REQ.byteenable[0] && AVM_REQ.writedata[ST_MODE_REJECT]) begin
                            reject_next = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end else begin
                case (idx)
                    IDX_CLOCK_NOISE:    rdata_next = {24'h000000, clk_noise_reg};
                    IDX_REF_EDGE_POS:   rdata_next = {8'h00, edge_pos};     // R5
                    IDX_FULLSCALE:      rdata_next = {16'h0000, fs_reg};
                    IDX_POWER_MODE:     rdata_next = {24'h000000, mode_reg};
                    IDX_TIMESTAMP_CTRL: rdata_next = {24'h000000, timestamp_input_reg};
                    IDX_STATUS: begin
                        rdata_next                 = 32'h00000000;
                        rdata_next[ST_LOW_POWER]   = (mode_reg == MODE_LOW_POWER);
                        rdata_next[ST_MODE_REJECT] = reject_reg;
                        rdata_next[ST_FS_LOW]      = (fs_reg < FS_MIN_RECOMMENDED);
                    end
                    default:            rdata_next = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_noise_reg <= RST_CLOCK_NOISE; // R2
            fs_reg        <= RST_FULLSCALE;   // R7
            mode_reg      <= RST_POWER_MODE;  // R9
            timestamp_input_reg     <= RST_TIMESTAMP_CTRL;
            reject_reg    <= 1'b0;
            ack_reg       <= 1'b0;
            rdata_reg     <= 32'h00000000;
            resp_reg      <= 2'h0;
        end else if (CLK_EN) begin
            clk_noise_reg <= clk_noise_next;
            fs_reg        <= fs_next;
            mode_reg      <= mode_next;
            timestamp_input_reg     <= timestamp_input_next;
            reject_reg    <= reject_next;
            ack_reg       <= ack_next;
            rdata_reg     <= rdata_next;
            resp_reg      <= resp_next;
        end
    end

    // waitrequest low only in the answer cycle
    assign AVM_WAITREQUEST = !ack_reg;
    assign AVM_READDATA    = rdata_reg;
    assign AVM_RESPONSE    = resp_reg;

    // analog control outputs straight from the stored fields
    assign ANALOG_CTRL.analog_clock_supply_quiet_en = clk_noise_reg[BIT_ANALOG_QUIET]; // R3
    assign ANALOG_CTRL.clock_core_supply_quiet_en   = clk_noise_reg[BIT_CORE_QUIET];   // R4
    assign ANALOG_CTRL.fullscale_range              = fs_reg;                          // R7
    assign ANALOG_CTRL.low_power_mode               = (mode_reg == MODE_LOW_POWER);    // R9
    assign ANALOG_CTRL.timestamp_input_control      = timestamp_input_reg;

    // mode register holds only the two legal codes
    a_mode_legal: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R9
        (mode_reg == MODE_HIGH_PERF) || (mode_reg == MODE_LOW_POWER))
        else $error("power mode holds a reserved code");

    // a reserved mode write leaves the mode unchanged and sets reject
    a_mode_reject: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R9
        (CLK_EN && req && AVM_REQ.write && idx == IDX_POWER_MODE && AVM_REQ.byteenable[0] &&
         AVM_REQ.writedata[7:0] != MODE_HIGH_PERF && AVM_REQ.writedata[7:0] != MODE_LOW_POWER)
        |=> (reject_reg && $stable(mode_reg)))
        else $error("reserved mode code not refused");

    // analog quiet enable follows a write of bit 2
    a_analog_quiet: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R3
        (CLK_EN && req && AVM_REQ.write && idx == IDX_CLOCK_NOISE && AVM_REQ.byteenable[0])
        |=> (ANALOG_CTRL.analog_clock_supply_quiet_en ==
             $past(AVM_REQ.writedata[BIT_ANALOG_QUIET])))
        else $error("analog quiet enable not updated");

    // core quiet enable follows a write of bit 0
    a_core_quiet: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R4
        (CLK_EN && req && AVM_REQ.write && idx == IDX_CLOCK_NOISE && AVM_REQ.byteenable[0])
        |=> (ANALOG_CTRL.clock_core_supply_quiet_en == $past(AVM_REQ.writedata[0])))
        else $error("core quiet enable not updated");

    // full-scale write lands in the output
    a_fs_write: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R7
        (CLK_EN && req && AVM_REQ.write && idx == IDX_FULLSCALE && AVM_REQ.byteenable == 4'hF)
        |=> (ANALOG_CTRL.fullscale_range == $past(AVM_REQ.writedata[15:0])))
        else $error("full-scale range not updated");

    // position read returns zero-extended capture
    a_pos_read: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R5
        (CLK_EN && req && AVM_REQ.read && idx == IDX_REF_EDGE_POS)
        |=> (AVM_READDATA == {8'h00, $past(edge_pos)} && !AVM_WAITREQUEST))
        else $error("edge position read wrong");

    // a request is answered in exactly one wait cycle
    a_bus_answer: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (CLK_EN && req) |=> !AVM_WAITREQUEST)
        else $error("bus request not answered");

    // position register is read-only
    a_pos_ro: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R5
        (CLK_EN && req && AVM_REQ.write && idx == IDX_REF_EDGE_POS)
        |=> ($stable(clk_noise_reg) && $stable(fs_reg) && $stable(mode_reg)))
        else $error("write to position altered a register");

    // a low clock enable freezes the bus answer, the reject flag and the clock noise, full-scale and mode fields
    a_enable_freeze: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !CLK_EN |=> ($stable(ack_reg) && $stable(clk_noise_reg) && $stable(fs_reg) &&
                     $stable(mode_reg) && $stable(reject_reg)))
        else $error("state moved while clock enable low");

    // writing one to the reject bit clears the sticky flag
    a_reject_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (CLK_EN && req && AVM_REQ.write && idx == IDX_STATUS && AVM_REQ.byteenable[0] &&
         AVM_REQ.writedata[ST_MODE_REJECT]) |=> !reject_reg)
        else $error("mode reject flag not cleared");
endmodule // conv_regs

// *** testbench/test_conv_regs.sv ***
// self-checking bench for the converter clock, range and power register bank
// assumes the bank answers each Avalon-MM request after one waitrequest-high cycle
module test_conv_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import conv_regs_pkg::*;

    logic         ref_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         clk_en = 1'b1;
    avm_req_t     req = '0;
    logic         waitreq;
    logic [31:0]  rdata;
    logic [1:0]   resp;
    logic         pos_toggle = 1'b0;
    logic [23:0]  pos_word = 24'h000000;
    analog_ctrl_t actl;
    int           error_cnt = 0;
    int           n_compared = 0;

    // 10 MHz reference clock
    always #50 ref_clk = ~ref_clk;

    conv_regs conv_regs_i (
        .REF_CLK(ref_clk), .RST_N(rst_n), .CLK_EN(clk_en), .AVM_REQ(req),
        .AVM_WAITREQUEST(waitreq), .AVM_READDATA(rdata), .AVM_RESPONSE(resp),
        .POS_TOGGLE(pos_toggle), .POS_WORD(pos_word), .ANALOG_CTRL(actl)
    );

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one bus cycle; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
        int n;
        n = 0;
        req.address <= a;
        req.writedata <= d;
        req.byteenable <= be;
        req.read <= !wr;
        req.write <= wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (n >= 50) check("bus answer", 32'h1, 32'h0);
        rd = rdata;
        rs = resp;
        req.read <= 1'b0;
        req.write <= 1'b0;
        // an idle edge keeps the next request out of this time step
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] rd;
        logic [1:0]  rs;
        bus(1'b1, {idx, 2'b00}, d, be, rd, rs);
        check("write response", {30'h0, rs}, 32'h0);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic [1:0]  rs;
        bus(1'b0, {idx, 2'b00}, 32'h0, 4'hF, rd, rs);
        check(nm, rd, exp);
        check("read response", {30'h0, rs}, 32'h0);
    endtask

    task automatic t_reset;
        rd_chk("clock noise", IDX_CLOCK_NOISE, 32'h10);
        rd_chk("edge position", IDX_REF_EDGE_POS, 32'h0);
        rd_chk("fullscale", IDX_FULLSCALE, 32'hA000);
        rd_chk("power mode", IDX_POWER_MODE, 32'h4B);
        rd_chk("timestamp", IDX_TIMESTAMP_CTRL, 32'h0);
        check("quiet enables", {30'h0, actl.analog_clock_supply_quiet_en,
              actl.clock_core_supply_quiet_en}, 32'h0);
        check("low power out", {31'h0, actl.low_power_mode}, 32'h0);
        $display("test reset values done");
    endtask

    task automatic t_quiet;
        // reserved bits keep their defaults in every write below
        wr(IDX_CLOCK_NOISE, 32'h14, 4'hF);
        check("analog quiet on", {31'h0, actl.analog_clock_supply_quiet_en}, 32'h1);
        check("core quiet off", {31'h0, actl.clock_core_supply_quiet_en}, 32'h0);
        wr(IDX_CLOCK_NOISE, 32'h11, 4'hF);
        check("analog quiet off", {31'h0, actl.analog_clock_supply_quiet_en}, 32'h0);
        check("core quiet on", {31'h0, actl.clock_core_supply_quiet_en}, 32'h1);
        rd_chk("clock noise back", IDX_CLOCK_NOISE, 32'h11);
        wr(IDX_CLOCK_NOISE, 32'h10, 4'hF);
        $display("test quiet enables done");
    endtask

    task automatic t_fs;
        // every setting stays inside the recommended range
        wr(IDX_FULLSCALE, 32'h2000, 4'hF);
        check("fullscale out", {16'h0, actl.fullscale_range}, 32'h2000);
        wr(IDX_FULLSCALE, 32'hFFFF, 4'h1);
        rd_chk("fullscale lane", IDX_FULLSCALE, 32'h20FF);
        wr(IDX_FULLSCALE, 32'hFFFF, 4'hF);
        check("fullscale max", {16'h0, actl.fullscale_range}, 32'hFFFF);
        $display("test fullscale done");
    endtask

    task automatic t_mode;
        // companions, calibration and link enable live outside this bank;
        // the bench stands in for software that handles them around each write
        wr(IDX_POWER_MODE, {24'h0, MODE_LOW_POWER}, 4'hF);
        check("low power on", {31'h0, actl.low_power_mode}, 32'h1);
        wr(IDX_POWER_MODE, 32'h55, 4'hF);    // reserved code must not land
        rd_chk("mode kept", IDX_POWER_MODE, 32'h46);
        rd_chk("status reject", IDX_STATUS, 32'h3);
        wr(IDX_STATUS, 32'h2, 4'hF);
        wr(IDX_POWER_MODE, {24'h0, MODE_HIGH_PERF}, 4'hF);
        check("low power off", {31'h0, actl.low_power_mode}, 32'h0);
        rd_chk("mode high perf", IDX_POWER_MODE, 32'h4B);
        rd_chk("status clear", IDX_STATUS, 32'h0);
        $display("test power mode done");
    endtask

    task automatic t_pos;
        logic [31:0] rd;
        logic [1:0]  rs;
        pos_word <= 24'hA5C3E1;
        repeat (4) @(posedge ref_clk);
        pos_toggle <= 1'b1;
        // word held well beyond the synchroniser's settling time
        repeat (10) @(posedge ref_clk);
        rd_chk("edge position new", IDX_REF_EDGE_POS, 32'hA5C3E1);
        wr(IDX_REF_EDGE_POS, 32'h123456, 4'hF);
        rd_chk("edge position ro", IDX_REF_EDGE_POS, 32'hA5C3E1);
        bus(1'b0, 10'h3FC, 32'h0, 4'hF, rd, rs);
        check("unmapped response", {30'h0, rs}, 32'h2);
        check("unmapped data", rd, 32'h0);
        $display("test edge position done");
    endtask

    // request held while the clock enable is low must wait, then land
    task automatic t_freeze;
        int n;
        n = 0;
        clk_en <= 1'b0;
        req.address <= {IDX_FULLSCALE, 2'b00};
        req.writedata <= 32'h3000;
        req.byteenable <= 4'hF;
        req.write <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("frozen wait", {31'h0, waitreq}, 32'h1);
        check("frozen fullscale", {16'h0, actl.fullscale_range}, 32'hFFFF);
        clk_en <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (n >= 50) check("freeze answer", 32'h1, 32'h0);
        req.write <= 1'b0;
        @(posedge ref_clk);
        check("fullscale thawed", {16'h0, actl.fullscale_range}, 32'h3000);
        $display("test clock enable done");
    endtask

    // a reset in mid-run restores every default
    task automatic t_rst_mid;
        wr(IDX_CLOCK_NOISE, 32'h15, 4'hF);
        wr(IDX_TIMESTAMP_CTRL, 32'h03, 4'hF);
        rd_chk("timestamp back", IDX_TIMESTAMP_CTRL, 32'h03);
        rst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        $display("test mid-run reset done");
    endtask

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_quiet();
        t_fs();
        t_mode();
        t_freeze();
        t_rst_mid();
        t_pos();
        complete_run();
    end

    // watchdog far beyond the 130 or so cycles the tests need
    initial begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        complete_run();
    end
endmodule // test_conv_regs
